// *** logic/eep_pkg.sv ***
package eep_pkg;

	// ----------------------------------------------------------------
	// Bus framing
	// ----------------------------------------------------------------
	localparam logic [3:0] DEV_PREFIX = 4'ha;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;

	// ----------------------------------------------------------------
	// Memory organisation
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int OFFS_W = 7;
	localparam int PAGE_W = 9;
	localparam logic [7:0] PAGE_BYTES = 8'h80;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int WR_TIME_NS = 5000000;
	localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_AHI,
		ST_ALO,
		ST_WDAT,
		ST_RDAT
	} eep_state_t;

endpackage

// *** logic/eep_mem.sv ***
module eep_mem #(
	parameter int AW = 16,
	parameter int DW = 8,
	parameter logic [7:0] INIT = 8'hff
) (
	input wire logic clk,            // Clock
	input wire logic wrEn,           // Write strobe
	input wire logic [AW-1:0] wrAddr, // Write address
	input wire logic [DW-1:0] wrData, // Write data
	input wire logic [AW-1:0] rdAddr, // Read address
	output logic [DW-1:0] rdData     // Registered read data
);

	logic [DW-1:0] store [0:(1<<AW)-1];

	if (DW != 8) begin : g_chk
		$error("eep_mem supports byte-wide words only");
	end

	// R19 erased contents
	initial begin
		for (int i = 0; i < (1 << AW); i++) begin
			store[i] = INIT;
		end
	end

	always_ff @(posedge clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
		rdData <= store[rdAddr];
	end

endmodule

// *** logic/eep_fifo.sv ***
module eep_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16
) (
	input wire logic clk,              // Clock
	input wire logic rst_n,            // Async reset, active low
	input wire logic inValid,          // Write request
	output logic inReady,              // Space available
	input wire logic [WIDTH-1:0] inData, // Write data
	output logic outValid,             // Data available
	input wire logic outReady,         // Consumer takes word
	output logic [WIDTH-1:0] outData   // Head word
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] slot [0:DEPTH-1];
	logic [PW:0] wrPtr_q;
	logic [PW:0] rdPtr_q;
	logic doWr;
	logic doRd;

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
		$error("eep_fifo depth must be a power of two");
	end

	// Extra pointer bit tells full from empty
	assign outValid = wrPtr_q != rdPtr_q;
	assign inReady = wrPtr_q != {~rdPtr_q[PW], rdPtr_q[PW-1:0]};
	assign doWr = inValid & inReady;
	assign doRd = outValid & outReady;
	assign outData = slot[rdPtr_q[PW-1:0]];

	always_ff @(posedge clk) begin
		if (doWr) begin
			slot[wrPtr_q[PW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_q + (PW+1)'(doWr);
			rdPtr_q <= rdPtr_q + (PW+1)'(doRd);
		end
	end

endmodule

// *** logic/eep_slave.sv ***
// Contract
// R1 - Reset holds all state; release enters standby awaiting a start.
// R2 - Sample data on clock rise, change output on fall, drive only low.
// R3 - Write-protect high refuses memory writes; low has no effect.
// R4 - Start and stop framed while clock high; ignore bus until start.
// R5 - Stop after write launches write cycle; after read returns to standby.
// R6 - Any data change while clock high is a start or stop.
// R7 - Address byte must be 1010 plus three strap bits; last bit read.
// R8 - Acknowledge matched address, address bytes and write data in ninth clock.
// R9 - Read shifts out bytes, releases in ninth clock, continues on acknowledge.
// R10 - Byte write acknowledges four bytes, write starts at stop.
// R11 - No address acknowledge while the internal write runs.
// R12 - Address splits into 9-bit page and 7-bit offset.
// R13 - Write offset increments and wraps within page; up to 128 bytes committed.
// R14 - Sample write-protect before first data byte; high means nack and discard.
// R15 - Address counter holds next location, rolling over to zero.
// R16 - Read address byte acknowledged, then byte at counter sent.
// R17 - Dummy write loads counter without writing memory.
// R18 - Each master acknowledge sends next byte; counter wraps whole memory.
// R19 - Memory starts fully erased.
// R20 - Write cycle lasts a parameter count; busy until it expires.
// R21 - Bus pins synchronised to system clock, edges found there.
module eep_slave
	import eep_pkg::*;
#(
	parameter int WRITE_CYCLES = WR_CYCLES
) (
	input wire logic ref_clk,        // System clock, 200 MHz
	input wire logic rst_n,          // Power-on reset, active low
	input wire logic scl,            // Bus clock pin
	input wire logic sdaIn,          // Bus data pin level
	output logic sdaOut,             // Bus data drive value, always low
	output logic sdaOe,              // Bus data pull-down enable
	input wire logic chipSelectHi,   // Address strap, upper
	input wire logic chipSelectMid,  // Address strap, middle
	input wire logic chipSelectLo,   // Address strap, lower
	input wire logic writeProtect,   // Write protect pin
	output logic writeBusy           // Internal write cycle running
);

	if (WRITE_CYCLES < 32'(PAGE_BYTES) + 2) begin : g_chk
		$error("WRITE_CYCLES too short to commit a page");
	end

	localparam int FW = OFFS_W + DATA_W;

	function automatic logic [ADDR_W-1:0] nextInPage(input logic [ADDR_W-1:0] a);
		nextInPage = {a[ADDR_W-1:OFFS_W], a[OFFS_W-1:0] + OFFS_W'(1)};
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [5:0] pinMeta_q;
	logic [5:0] pinSync_q;
	logic sclPrev_q;
	logic sdaPrev_q;
	logic sclS;
	logic sdaS;
	logic wpS;
	logic [2:0] strapS;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	// R21 two-stage sync
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_q <= 6'h03;
			pinSync_q <= 6'h03;
		end else begin
			pinMeta_q <= {writeProtect, chipSelectHi, chipSelectMid, chipSelectLo, sdaIn, scl};
			pinSync_q <= pinMeta_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	assign sclS = pinSync_q[0];
	assign sdaS = pinSync_q[1];
	assign strapS = pinSync_q[4:2];
	assign wpS = pinSync_q[5];
	// R21 edges in system domain
	assign sclRise = sclS & ~sclPrev_q;
	assign sclFall = ~sclS & sclPrev_q;
	// R4 start and stop framing
	// R6 data change with clock high
	assign startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
	assign stopSeen = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

	// ----------------------------------------------------------------
	// Protocol state
	// ----------------------------------------------------------------
	eep_state_t state_q, state_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] rxSh_q, rxSh_d;
	logic [7:0] txSh_q, txSh_d;
	logic sdaOe_q, sdaOe_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [7:0] addrHi_q, addrHi_d;
	logic wpLat_q, wpLat_d;
	logic pending_q, pending_d;
	logic mAck_q, mAck_d;
	logic rw_q, rw_d;
	logic bitOpen_q, bitOpen_d;
	logic launch;
	logic fifoPush;
	logic clrValid;
	logic devHit;
	logic fifoInReady;
	logic [7:0] memRdData;

	logic busy_q;

	// R7 address match
	// R11 busy blocks the match
	assign devHit = (rxSh_q[7:1] == {DEV_PREFIX, strapS}) & ~busy_q;

	always_comb begin
		state_d = state_q;
		bitCnt_d = bitCnt_q;
		rxSh_d = rxSh_q;
		txSh_d = txSh_q;
		sdaOe_d = sdaOe_q;
		addr_d = addr_q;
		addrHi_d = addrHi_q;
		wpLat_d = wpLat_q;
		pending_d = pending_q;
		mAck_d = mAck_q;
		rw_d = rw_q;
		bitOpen_d = bitOpen_q;
		launch = 1'b0;
		fifoPush = 1'b0;
		clrValid = 1'b0;
		if (stopSeen) begin
			// R5 stop ends command
			// R10 write starts at stop
			state_d = ST_IDLE;
			sdaOe_d = 1'b0;
			launch = pending_q;
			pending_d = 1'b0;
		end else if (startSeen) begin
			// A start without stop drops unfinished write data
			state_d = ST_DEV;
			bitOpen_d = 1'b0;
			bitCnt_d = BIT_FIRST;
			sdaOe_d = 1'b0;
			pending_d = 1'b0;
		end else if (state_q != ST_IDLE) begin
			if (sclRise) begin
				bitOpen_d = 1'b1;
				// R2 sample on rising clock
				if (bitCnt_q != BIT_ACK) begin
					rxSh_d = {rxSh_q[6:0], sdaS};
				end else begin
					mAck_d = ~sdaS;
				end
			end else if (sclFall && bitOpen_q) begin
				// The fall that closes a start is no data bit, so only a seen rise counts
				bitOpen_d = 1'b0;
				if (bitCnt_q == BIT_LAST) begin
					bitCnt_d = BIT_ACK;
					unique case (state_q)
						ST_DEV: begin
							// R8 address acknowledge
							if (devHit) begin
								sdaOe_d = 1'b1;
								rw_d = rxSh_q[0];
							end else begin
								state_d = ST_IDLE;
							end
						end
						ST_AHI: begin
							sdaOe_d = 1'b1;
							addrHi_d = rxSh_q;
						end
						ST_ALO: begin
							// R17 counter loaded, nothing written
							sdaOe_d = 1'b1;
							addr_d = {addrHi_q, rxSh_q};
						end
						ST_WDAT: begin
							// R14 protected write refused
							// R3 no write while protected
							if (wpLat_q) begin
								state_d = ST_IDLE;
								pending_d = 1'b0;
							end else if (fifoInReady) begin
								// R13 wrap within page
								sdaOe_d = 1'b1;
								fifoPush = 1'b1;
								pending_d = 1'b1;
								addr_d = nextInPage(addr_q);
							end
						end
						ST_RDAT: begin
							// R9 release for master acknowledge
							sdaOe_d = 1'b0;
						end
						default: begin
							state_d = ST_IDLE;
						end
					endcase
				end else if (bitCnt_q == BIT_ACK) begin
					bitCnt_d = BIT_FIRST;
					sdaOe_d = 1'b0;
					unique case (state_q)
						ST_DEV: begin
							if (rw_q) begin
								// R16 send byte at counter
								// R15 counter moves past it
								state_d = ST_RDAT;
								txSh_d = memRdData;
								sdaOe_d = ~memRdData[7];
								addr_d = addr_q + ADDR_W'(1);
							end else begin
								state_d = ST_AHI;
							end
						end
						ST_AHI: begin
							state_d = ST_ALO;
						end
						ST_ALO: begin
							// R14 strobe on last fall before data
							state_d = ST_WDAT;
							wpLat_d = wpS;
							clrValid = 1'b1;
						end
						ST_WDAT: begin
							state_d = ST_WDAT;
						end
						ST_RDAT: begin
							// R18 next byte on acknowledge, full wrap
							if (mAck_q) begin
								txSh_d = memRdData;
								sdaOe_d = ~memRdData[7];
								addr_d = addr_q + ADDR_W'(1);
							end else begin
								state_d = ST_IDLE;
							end
						end
						default: begin
							state_d = ST_IDLE;
						end
					endcase
				end else begin
					bitCnt_d = bitCnt_q + 4'h1;
					if (state_q == ST_RDAT) begin
						// R2 change output on falling clock
						txSh_d = {txSh_q[6:0], 1'b0};
						sdaOe_d = ~txSh_q[6];
					end
				end
			end
		end
	end

	// R1 reset holds standby state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			bitCnt_q <= BIT_FIRST;
			rxSh_q <= 8'h00;
			txSh_q <= 8'h00;
			sdaOe_q <= 1'b0;
			addr_q <= 16'h0000;
			addrHi_q <= 8'h00;
			wpLat_q <= 1'b0;
			pending_q <= 1'b0;
			mAck_q <= 1'b0;
			rw_q <= 1'b0;
			bitOpen_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bitCnt_q <= bitCnt_d;
			rxSh_q <= rxSh_d;
			txSh_q <= txSh_d;
			sdaOe_q <= sdaOe_d;
			addr_q <= addr_d;
			addrHi_q <= addrHi_d;
			wpLat_q <= wpLat_d;
			pending_q <= pending_d;
			mAck_q <= mAck_d;
			rw_q <= rw_d;
			bitOpen_q <= bitOpen_d;
		end
	end

	// R2 open drain, low or released
	assign sdaOut = 1'b0;
	assign sdaOe = sdaOe_q;

	// ----------------------------------------------------------------
	// Page buffer fill
	// ----------------------------------------------------------------
	logic [FW-1:0] fifoOutData;
	logic fifoOutValid;
	logic drain;
	logic [PAGE_BYTES-1:0] pageValid_q;
	logic [7:0] pageRdData;
	logic [7:0] cIdx_q;
	logic [OFFS_W-1:0] cOff_q;
	logic cStage_q;

	// Bytes arrive far slower than they drain, so a full fifo nacks the byte
	eep_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData({addr_q[OFFS_W-1:0], rxSh_q}),
		.outValid(fifoOutValid),
		.outReady(drain),
		.outData(fifoOutData)
	);

	assign drain = fifoOutValid & ~busy_q;

	eep_mem #(
		.AW(OFFS_W),
		.DW(DATA_W),
		.INIT(ERASED_BYTE)
	) u_page (
		.clk(ref_clk),
		.wrEn(drain),
		.wrAddr(fifoOutData[FW-1:DATA_W]),
		.wrData(fifoOutData[DATA_W-1:0]),
		.rdAddr(cIdx_q[OFFS_W-1:0]),
		.rdData(pageRdData)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pageValid_q <= '0;
		end else if (clrValid) begin
			pageValid_q <= '0;
		end else if (drain) begin
			pageValid_q[fifoOutData[FW-1:DATA_W]] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Internal write cycle
	// ----------------------------------------------------------------
	logic [31:0] busyCnt_q;
	logic [PAGE_W-1:0] pageNum_q;
	logic busyDone;
	logic memWr;

	// R20 fixed-length busy period
	assign busyDone = busyCnt_q == 32'(WRITE_CYCLES - 1);
	// R12 page number and offset form the address
	// R13 only loaded bytes are committed
	assign memWr = cStage_q & pageValid_q[cOff_q];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			busyCnt_q <= 32'h0;
			pageNum_q <= '0;
		end else if (launch) begin
			busy_q <= 1'b1;
			busyCnt_q <= 32'h0;
			pageNum_q <= addr_q[ADDR_W-1:OFFS_W];
		end else if (busy_q) begin
			busy_q <= ~busyDone;
			busyCnt_q <= busyCnt_q + 32'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cIdx_q <= 8'h00;
			cOff_q <= '0;
			cStage_q <= 1'b0;
		end else if (launch) begin
			cIdx_q <= 8'h00;
			cStage_q <= 1'b0;
		end else if (busy_q && cIdx_q != PAGE_BYTES) begin
			cIdx_q <= cIdx_q + 8'h01;
			cOff_q <= cIdx_q[OFFS_W-1:0];
			cStage_q <= 1'b1;
		end else begin
			cStage_q <= 1'b0;
		end
	end

	// R19 array starts erased
	eep_mem #(
		.AW(ADDR_W),
		.DW(DATA_W),
		.INIT(ERASED_BYTE)
	) u_array (
		.clk(ref_clk),
		.wrEn(memWr),
		.wrAddr({pageNum_q, cOff_q}),
		.wrData(pageRdData),
		.rdAddr(addr_q),
		.rdData(memRdData)
	);

	assign writeBusy = busy_q;

endmodule

// *** dv/eep_slave_props.sv ***
module eep_slave_props
	import eep_pkg::*;
#(
	parameter int WRITE_CYCLES = WR_CYCLES
) (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic scl, // Bus clock
	input wire logic sdaIn, // Bus data
	input wire logic sdaOut, // Drive value
	input wire logic sdaOe, // Drive enable
	input wire logic chipSelectHi, // Strap
	input wire logic chipSelectMid, // Strap
	input wire logic chipSelectLo, // Strap
	input wire logic writeProtect, // Protect pin
	input wire logic writeBusy // Write cycle
);
	// ----------------------------------------
	// Bus tracking on raw pins
	// ----------------------------------------
	logic sclQ, sdaQ, seen, first, rdMode;
	logic [3:0] bitCnt;
	logic [7:0] shReg;
	int busyCnt;
	wire sclRise = scl && !sclQ;
	wire startSeen = scl && sclQ && sdaQ && !sdaIn;
	wire ninth = sclRise && bitCnt == BIT_ACK;
	wire [6:0] devId = {DEV_PREFIX, chipSelectHi, chipSelectMid, chipSelectLo};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			seen <= 1'b0;
			first <= 1'b1;
			bitCnt <= 4'h0;
			busyCnt <= 0;
		end else begin
			sclQ <= scl;
			sdaQ <= sdaIn;
			busyCnt <= writeBusy ? busyCnt + 1 : 0;
			if (startSeen) begin
				seen <= 1'b1;
				first <= 1'b1;
				bitCnt <= 4'h0;
			end else if (sclRise) begin
				first <= first && !ninth;
				bitCnt <= ninth ? 4'h0 : bitCnt + 4'h1;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (sclRise && bitCnt < BIT_ACK) shReg <= {shReg[6:0], sdaIn};
		if (ninth && first) rdMode <= shReg[0];
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_busy_start;
		!writeBusy ##1 writeBusy;
	endsequence
	a_drive_low_only: assert property (sdaOe |-> !sdaOut)
		else $error("data driven high");
	a_rise_scl_low: assert property ($rose(sdaOe) |-> !scl)
		else $error("drive began with clock high");
	a_quiet_till_start: assert property (!seen |-> !sdaOe)
		else $error("drive before any start");
	a_addr_bits_free: assert property (sclRise && first && bitCnt < BIT_ACK |-> !sdaOe)
		else $error("drive during address bits");
	a_addr_match: assert property (ninth && first && sdaOe |-> shReg[7:1] == devId && !writeBusy)
		else $error("ack on foreign address");
	a_read_release: assert property (ninth && !first && rdMode |-> !sdaOe)
		else $error("ninth clock held in read");
	a_drive_bounded: assert property ($rose(sdaOe) |-> ##[1:120] !sdaOe)
		else $error("data held low too long");
	a_busy_quiet: assert property (writeBusy |-> !sdaOe)
		else $error("drive while busy");
	a_busy_idle_bus: assert property ($rose(writeBusy) |-> scl && sdaIn)
		else $error("write began off a stop");
	a_busy_hold: assert property (s_busy_start |=> writeBusy [*8])
		else $error("write cycle cut short");
	a_busy_length: assert property ($fell(writeBusy) |-> busyCnt == WRITE_CYCLES)
		else $error("write cycle length wrong");
endmodule

// *** dv/eep_bus_master.sv ***
module eep_bus_master (
	output logic scl, // Bus clock
	output logic sdaLow, // Master pulls data low
	input wire logic sdaLine // Resolved data line
);
	timeunit 1ns;
	timeprecision 100ps;
	// Quarter of the 48 ns bus period; data moves mid-low, sampled mid-high
	localparam int Q = 12;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// data changes only while clock is low
	task automatic bit_io(input logic b, output logic r);
		#Q sdaLow = ~b;
		#Q scl = 1'b1;
		#Q r = sdaLine;
		#Q scl = 1'b0;
	endtask
	// start is data falling with clock high
	task automatic start();
		#Q sdaLow = 1'b0;
		#Q scl = 1'b1;
		#Q sdaLow = 1'b1;
		#Q scl = 1'b0;
	endtask
	// stop is data rising with clock high
	task automatic stop();
		#Q sdaLow = 1'b1;
		#Q scl = 1'b1;
		#Q sdaLow = 1'b0;
		#(3 * Q);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		// ack to continue, nack ends the read
		bit_io(~more, r);
	endtask
endmodule

// *** dv/tb.sv ***
module tb;
	import eep_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WC = 200;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp = 1'b0;
	logic [2:0] cs = 3'h0;
	wire sdaOut, sdaOe, writeBusy, scl, sdaLow;
	// Pull-up: a released line reads high
	wire sdaIn = ~(sdaLow | sdaOe);
	int n_fail = 0;
	int n_checks = 0;
	logic [7:0] mem [logic [15:0]];
	logic a;
	logic [7:0] d;
	logic [15:0] ad;
	always #2.5 ref_clk = ~ref_clk;
	eep_bus_master m (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaIn));
	eep_slave #(.WRITE_CYCLES(WC)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectHi(cs[2]),
		.chipSelectMid(cs[1]), .chipSelectLo(cs[0]), .writeProtect(wp), .writeBusy(writeBusy));
	function automatic logic [7:0] exp_byte(input logic [15:0] k);
		return mem.exists(k) ? mem[k] : ERASED_BYTE;
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tx(input logic [7:0] b, input logic e);
		m.wbyte(b, a);
		check({7'h0, a}, {7'h0, e});
	endtask
	task automatic rd(input logic [15:0] adr, input int n, input logic pick);
		if (pick) begin
			m.start();
			tx({DEV_PREFIX, cs, 1'b0}, 1'b1);
			tx(adr[15:8], 1'b1);
			tx(adr[7:0], 1'b1);
		end
		m.start();
		tx({DEV_PREFIX, cs, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i < n - 1, d);
			check(d, exp_byte(adr));
			adr++;
		end
		m.stop();
	endtask
	task automatic wr(input logic [15:0] adr, input int n);
		logic [7:0] v;
		m.start();
		tx({DEV_PREFIX, cs, 1'b0}, 1'b1);
		tx(adr[15:8], 1'b1);
		tx(adr[7:0], 1'b1);
		for (int i = 0; i < n; i++) begin
			v = 8'($urandom);
			tx(v, !wp);
			if (!wp) mem[{adr[15:7], adr[6:0] + 7'(i)}] = v;
		end
		m.stop();
		@(negedge ref_clk);
		check({7'h0, writeBusy}, {7'h0, !wp});
		if (!wp) begin
			m.start();
			tx({DEV_PREFIX, cs, 1'b0}, 1'b0);
			m.stop();
			for (int k = 0; k < 400 && writeBusy; k++) @(negedge ref_clk);
			check({7'h0, writeBusy}, 8'h0);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(32'he15e27cf));
		repeat (12) @(posedge ref_clk);
		cs <= 3'($urandom);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		check({6'h0, sdaOe, writeBusy}, 8'h0);
		rd(16'($urandom), 3, 1'b1);
		$display("erased read done");
		for (int i = 0; i < 4; i++) begin
			m.start();
			tx({DEV_PREFIX ^ 4'(i == 3), cs ^ 3'(1 << i), i[0]}, 1'b0);
			m.stop();
		end
		$display("address mismatch done");
		ad = 16'($urandom);
		wr(ad, 1);
		rd(ad, 1, 1'b1);
		$display("byte write done");
		ad = {9'($urandom), 7'h7e};
		wr(ad, 130);
		rd({ad[15:7], 7'h0}, 128, 1'b1);
		rd({ad[15:7] + 9'h1, 7'h0}, 1, 1'b0);
		$display("page write done");
		@(posedge ref_clk) wp <= 1'b1;
		wr(ad, 2);
		@(posedge ref_clk) wp <= 1'b0;
		rd(ad, 2, 1'b1);
		$display("write protect done");
		wr(16'hffff, 1);
		rd(16'hfffe, 3, 1'b1);
		$display("memory wrap done");
		m.start();
		tx({DEV_PREFIX, cs, 1'b1}, 1'b1);
		@(posedge ref_clk) rst_n <= 1'b0;
		@(negedge ref_clk);
		check({7'h0, sdaOe}, 8'h0);
		@(posedge ref_clk) rst_n <= 1'b1;
		m.stop();
		rd(16'hffff, 2, 1'b1);
		$display("reset mid-read done");
		finish_test();
	end
	initial begin
		#400us;
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule

bind eep_slave eep_slave_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
	.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .chipSelectHi(chipSelectHi), .chipSelectMid(chipSelectMid),
	.chipSelectLo(chipSelectLo), .writeProtect(writeProtect), .writeBusy(writeBusy));
